// [design/pieb_top.sv]
// Peripheral interrupt enable bank: four enable registers gating flags.
// Assumes flags are synchronous level inputs from peripherals.
`timescale 1ns/1ps
module pieb_top
	import pieb_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register port
	input wire pieb_req_t reg_req,
	output logic [7:0] reg_rdata,
	// Peripheral flags
	input wire pieb_bank_t irq_flags,
	// Request to core
	output logic periph_irq_req
);

	////////////////////////////////////////////////////////////////////////
	// Storage
	pieb_bank_t en_ff; // Enable bytes
	logic [1:0] ctrl_ff; // Global and group enables
	logic pend_ff; // Any enabled flag, ungated by global
	logic [7:0] nxt_rdata; // Read mux

	// Strip unimplemented positions from a byte
	function automatic logic [7:0] keep(input logic [7:0] v,
		input logic [7:0] m);
		keep = v & m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Enable register writes; masks make reserved bits stick at zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_ff <= {4{PIEB_RST_EN}};
		end else if (clk_en && reg_req.wr) begin
			unique case (reg_req.addr)
				PIEB_ADDR_EN_ONE: en_ff.one <= keep(reg_req.wdata, PIEB_MASK_ONE);
				PIEB_ADDR_EN_TWO: en_ff.two <= keep(reg_req.wdata, PIEB_MASK_TWO);
				PIEB_ADDR_EN_THREE: begin
					en_ff.three <= keep(reg_req.wdata, PIEB_MASK_THREE);
				end
				PIEB_ADDR_EN_FOUR: begin
					en_ff.four <= keep(reg_req.wdata, PIEB_MASK_FOUR);
				end
				default: begin
				end
			endcase
		end
	end

	// Control register: global and group enables
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= PIEB_RST_CTRL;
		end else if (clk_en && reg_req.wr && reg_req.addr == PIEB_ADDR_CTRL) begin
			ctrl_ff <= reg_req.wdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gating; flags are taken as given, never altered here
	// Bitwise AND covers every per-bit gate
	logic any_en;
	assign any_en = |(en_ff & irq_flags);

	// Pending qualified by group; global only masks the core request
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_ff <= 1'b0;
		end else if (clk_en) begin
			pend_ff <= any_en && ctrl_ff[PIEB_CTRL_GROUP_BIT];
		end
	end

	// Core request; a held pending request shows once global returns
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_irq_req <= 1'b0;
		end else if (clk_en) begin
			periph_irq_req <= any_en && ctrl_ff[PIEB_CTRL_GROUP_BIT]
				&& ctrl_ff[PIEB_CTRL_GLOBAL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero
	always_comb begin
		nxt_rdata = 8'h00;
		unique case (reg_req.addr)
			PIEB_ADDR_EN_ONE: nxt_rdata = en_ff.one;
			PIEB_ADDR_EN_TWO: nxt_rdata = en_ff.two;
			PIEB_ADDR_EN_THREE: nxt_rdata = en_ff.three;
			PIEB_ADDR_EN_FOUR: nxt_rdata = en_ff.four;
			PIEB_ADDR_CTRL: nxt_rdata = {6'h00, ctrl_ff};
			PIEB_ADDR_STATUS: nxt_rdata = {6'h00, periph_irq_req, pend_ff};
			default: nxt_rdata = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			reg_rdata <= reg_req.rd ? nxt_rdata : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence wr_one_s;
		clk_en && reg_req.wr && reg_req.addr == PIEB_ADDR_EN_ONE;
	endsequence

	gate_one_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_one_s |=> en_ff.one == $past(reg_req.wdata))
		else $error("enable one not stored");

	reserved_two_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		en_ff.two[2:1] == 2'h0 && en_ff.three[7:6] == 2'h0)
		else $error("reserved bits set");

	reserved_four_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		en_ff.four[7:2] == 6'h00 && en_ff.three[2] == 1'b0
		&& en_ff.three[0] == 1'b0)
		else $error("reserved bits set");

	group_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !ctrl_ff[PIEB_CTRL_GROUP_BIT] |=> !periph_irq_req)
		else $error("request passed group disable");

	global_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !ctrl_ff[PIEB_CTRL_GLOBAL_BIT] |=> !periph_irq_req)
		else $error("request passed global disable");

	req_raise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && any_en && ctrl_ff == 2'h3 |=> periph_irq_req)
		else $error("enabled flag not requested");

	gate_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && irq_flags == 32'h1 && !en_ff.one[0] |=> !periph_irq_req)
		else $error("masked flag passed");

	read_back_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_req.rd && reg_req.addr == PIEB_ADDR_EN_TWO
		|=> reg_rdata == $past(en_ff.two))
		else $error("read data wrong");

	////////////////////////////////////////////////////////////////////////
	// Per-bit gating checks
	// Each raises one flag alone, so the request can only come from it

	// One flag raised alone with both enables set
	sequence lone_flag_s(int pos);
		clk_en && ctrl_ff == 2'h3 && irq_flags == (32'h1 << pos);
	endsequence

	// Core request next cycle mirrors that flag's enable bit
	property lone_gate_p(int pos);
		lone_flag_s(pos) |=> periph_irq_req == $past(en_ff[pos]);
	endproperty

	// Timer-one gate acquisition request
	// Passes when set, blocked when clear
	timer_gate_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_TIMER_ONE_GATE))
		else $error("timer gate enable ignored");

	// Converter completion request
	// Passes when set, blocked when clear
	converter_gate_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_CONVERTER_DONE))
		else $error("converter enable ignored");

	// Serial receiver request
	// Passes when set, blocked when clear
	serial_rx_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_SERIAL_RX))
		else $error("receive enable ignored");

	// Serial transmitter request
	// Passes when set, blocked when clear
	serial_tx_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_SERIAL_TX))
		else $error("transmit enable ignored");

	// Sync port one transfer request
	// Passes when set, blocked when clear
	sync_one_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_SYNC_ONE))
		else $error("sync port one enable ignored");

	// Capture/compare one request
	// Passes when set, blocked when clear
	capcmp_one_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_CAPCMP_ONE))
		else $error("capcmp one enable ignored");

	// Timer-two period match request
	// Passes when set, blocked when clear
	timer_two_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_TIMER_TWO_MATCH))
		else $error("timer two enable ignored");

	// Timer-one overflow request
	// Passes when set, blocked when clear
	timer_ovf_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_TIMER_ONE_OVF))
		else $error("overflow enable ignored");

	// Oscillator failure request
	// Passes when set, blocked when clear
	osc_fail_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_OSC_FAIL))
		else $error("oscillator enable ignored");

	// Non-volatile write completion request
	// Passes when set, blocked when clear
	nv_done_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_NV_WRITE_DONE))
		else $error("write done enable ignored");

	// Sync port one collision request
	// Passes when set, blocked when clear
	one_collision_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_SYNC_ONE_COLL))
		else $error("collision one enable ignored");

	// Capture/compare two request
	// Passes when set, blocked when clear
	capcmp_two_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_CAPCMP_TWO))
		else $error("capcmp two enable ignored");

	// Capture/compare four request
	// Passes when set, blocked when clear
	capcmp_four_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_CAPCMP_FOUR))
		else $error("capcmp four enable ignored");

	// Capture/compare three request
	// Passes when set, blocked when clear
	capcmp_three_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_CAPCMP_THREE))
		else $error("capcmp three enable ignored");

	// Timer-six period match request
	// Passes when set, blocked when clear
	timer_six_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_TIMER_SIX_MATCH))
		else $error("timer six enable ignored");

	// Timer-four period match request
	// Passes when set, blocked when clear
	timer_four_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_TIMER_FOUR_MATCH))
		else $error("timer four enable ignored");

	// Sync port two collision request
	// Passes when set, blocked when clear
	two_collision_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_SYNC_TWO_COLL))
		else $error("collision two enable ignored");

	// Sync port two transfer request
	// Passes when set, blocked when clear
	sync_two_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_SYNC_TWO))
		else $error("sync port two enable ignored");

	// Comparator two request
	// Passes when set, blocked when clear
	comparator_two_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_COMPARATOR_TWO))
		else $error("comparator two enable ignored");

	// Comparator one request
	// Passes when set, blocked when clear
	comparator_one_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		lone_gate_p(PIEB_POS_COMPARATOR_ONE))
		else $error("comparator one enable ignored");

	////////////////////////////////////////////////////////////////////////
	// Port and bank-wide checks

	// Frozen clock enable holds every register
	// A strobe arriving then must not leak into state
	freeze_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!clk_en |=> $stable(en_ff) && $stable(ctrl_ff) && $stable(pend_ff)
		&& $stable(periph_irq_req) && $stable(reg_rdata))
		else $error("state moved while frozen");

	// Control write lands in the next cycle
	ctrl_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_req.wr && reg_req.addr == PIEB_ADDR_CTRL
		|=> ctrl_ff == $past(reg_req.wdata[1:0]))
		else $error("control not stored");

	// Writes to unmapped indices change nothing
	// Status is read-only, so it counts as unmapped for writes
	unmapped_write_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && reg_req.wr && reg_req.addr > PIEB_ADDR_CTRL
		|=> $stable(en_ff) && $stable(ctrl_ff))
		else $error("unmapped write took effect");

	// Read data idles at zero outside the answer cycle
	rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !reg_req.rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");

	// No enabled flag means no request to the core
	// Catches a gate that leaks a masked flag of any byte
	no_source_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && (en_ff & irq_flags) == 32'h0 |=> !periph_irq_req)
		else $error("request without enabled flag");

	// Group enable clear also keeps status pending low
	pend_group_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && !ctrl_ff[PIEB_CTRL_GROUP_BIT] |=> !pend_ff)
		else $error("pending passed group disable");

	// Read back of enable one
	read_one_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && reg_req.rd && reg_req.addr == PIEB_ADDR_EN_ONE
		|=> reg_rdata == $past(en_ff.one))
		else $error("enable one read wrong");

	// Read back of enable three
	read_three_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && reg_req.rd && reg_req.addr == PIEB_ADDR_EN_THREE
		|=> reg_rdata == $past(en_ff.three))
		else $error("enable three read wrong");

	// Read back of enable four
	read_four_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		clk_en && reg_req.rd && reg_req.addr == PIEB_ADDR_EN_FOUR
		|=> reg_rdata == $past(en_ff.four))
		else $error("enable four read wrong");

	// Read back of the control bits
	read_ctrl_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_req.rd && reg_req.addr == PIEB_ADDR_CTRL
		|=> reg_rdata == {6'h00, $past(ctrl_ff)})
		else $error("control read wrong");

	// Status shows request and pending as they stood at the strobe
	read_status_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_req.rd && reg_req.addr == PIEB_ADDR_STATUS
		|=> reg_rdata == {6'h00, $past(periph_irq_req), $past(pend_ff)})
		else $error("status read wrong");

endmodule

// [shared/pieb_pkg.sv]
// Constants and carrier types for the peripheral interrupt enable bank.
// Assumes a plain register port with read data one cycle after the strobe.
package pieb_pkg;

	// Register indices on the plain port
	localparam logic [2:0] PIEB_ADDR_EN_ONE = 3'h0;
	localparam logic [2:0] PIEB_ADDR_EN_TWO = 3'h1;
	localparam logic [2:0] PIEB_ADDR_EN_THREE = 3'h2;
	localparam logic [2:0] PIEB_ADDR_EN_FOUR = 3'h3;
	localparam logic [2:0] PIEB_ADDR_CTRL = 3'h4;
	localparam logic [2:0] PIEB_ADDR_STATUS = 3'h5;

	// Writable bit masks per enable register
	localparam logic [7:0] PIEB_MASK_ONE = 8'hff;
	localparam logic [7:0] PIEB_MASK_TWO = 8'hf9;
	localparam logic [7:0] PIEB_MASK_THREE = 8'h3a;
	localparam logic [7:0] PIEB_MASK_FOUR = 8'h03;

	// Reset values
	localparam logic [7:0] PIEB_RST_EN = 8'h00;
	localparam logic [1:0] PIEB_RST_CTRL = 2'h0;

	// Control register fields
	localparam int PIEB_CTRL_GLOBAL_BIT = 1;
	localparam int PIEB_CTRL_GROUP_BIT = 0;

	// Status register fields
	localparam int PIEB_STAT_PEND_BIT = 0;
	localparam int PIEB_STAT_REQ_BIT = 1;

	// Enable bit positions across the 32-bit bank (one = 7:0)
	localparam int PIEB_POS_TIMER_ONE_GATE = 7;
	localparam int PIEB_POS_CONVERTER_DONE = 6;
	localparam int PIEB_POS_SERIAL_RX = 5;
	localparam int PIEB_POS_SERIAL_TX = 4;
	localparam int PIEB_POS_SYNC_ONE = 3;
	localparam int PIEB_POS_CAPCMP_ONE = 2;
	localparam int PIEB_POS_TIMER_TWO_MATCH = 1;
	localparam int PIEB_POS_TIMER_ONE_OVF = 0;
	localparam int PIEB_POS_OSC_FAIL = 15;
	localparam int PIEB_POS_COMPARATOR_TWO = 14;
	localparam int PIEB_POS_COMPARATOR_ONE = 13;
	localparam int PIEB_POS_NV_WRITE_DONE = 12;
	localparam int PIEB_POS_SYNC_ONE_COLL = 11;
	localparam int PIEB_POS_CAPCMP_TWO = 8;
	localparam int PIEB_POS_CAPCMP_FOUR = 21;
	localparam int PIEB_POS_CAPCMP_THREE = 20;
	localparam int PIEB_POS_TIMER_SIX_MATCH = 19;
	localparam int PIEB_POS_TIMER_FOUR_MATCH = 17;
	localparam int PIEB_POS_SYNC_TWO_COLL = 25;
	localparam int PIEB_POS_SYNC_TWO = 24;

	// Four enable or flag bytes carried together
	typedef struct packed {
		logic [7:0] four;
		logic [7:0] three;
		logic [7:0] two;
		logic [7:0] one;
	} pieb_bank_t;

	// Register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pieb_req_t;

endpackage

// [testbench/pieb_flag_src.sv]
// Flag source model: peripheral request flags seen by the enable bank.
// Assumes the bench names which flags are raised, one word per cycle.
`timescale 1ns/1ps
module pieb_flag_src
	import pieb_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Conditions raised by the bench
	input wire pieb_bank_t raise,
	// Flag levels to the bank
	output pieb_bank_t irq_flags
);
	////////////////////////////////////////////////////////////////////////
	// Flags follow their condition, never the enables, so a masked
	// source still raises its flag
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_flags <= '0;
		end else begin
			irq_flags <= raise;
		end
	end
endmodule

// [testbench/tb.sv]
// Self-checking bench for the peripheral interrupt enable bank.
// Assumes the flag source model and a register port without waits.
`timescale 1ns/1ps
module tb;
	import pieb_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	pieb_req_t reg_req = '0;
	pieb_bank_t raise = '0;
	pieb_bank_t irq_flags;
	logic [7:0] reg_rdata;
	logic periph_irq_req;
	int n_mismatch = 0;
	int checks = 0;
	// Writable bits of all four enables, one above the other
	localparam logic [31:0] MASKS = {PIEB_MASK_FOUR, PIEB_MASK_THREE,
		PIEB_MASK_TWO, PIEB_MASK_ONE};
	always #2.5 ref_clk = ~ref_clk;
	pieb_top pieb_top_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.irq_flags(irq_flags), .periph_irq_req(periph_irq_req));
	pieb_flag_src pieb_flag_src_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.raise(raise), .irq_flags(irq_flags));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		reg_req.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		reg_req.rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// Model adds one cycle, the bank one more; three edges is settled
	task automatic irq(input logic [31:0] f, input logic e);
		@(posedge ref_clk);
		raise <= f;
		repeat (3) @(posedge ref_clk);
		#1 chk({7'h00, periph_irq_req}, {7'h00, e});
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic reset_values;
		for (int i = 0; i < 5; i++) begin
			rd(3'(i), 8'h00);
		end
	endtask
	// Reserved bits drop writes; index 6 is unmapped and reads zero
	task automatic reserved_bits;
		for (int i = 0; i < 4; i++) begin
			wr(3'(i), 8'hff);
			rd(3'(i), MASKS[i*8 +: 8]);
			wr(3'(i), 8'h00);
			rd(3'(i), 8'h00);
		end
		wr(3'h6, 8'hff);
		rd(3'h6, 8'h00);
	endtask
	// Each enable passes its own flag only, all others raised too
	task automatic per_bit_gating;
		wr(PIEB_ADDR_CTRL, 8'h03);
		for (int b = 0; b < 32; b++) begin
			if (MASKS[b]) begin
				wr(3'(b / 8), 8'h01 << (b % 8));
				irq(32'h1 << b, 1'b1);
				irq(~(32'h1 << b), 1'b0);
				wr(3'(b / 8), 8'h00);
			end
		end
	endtask
	// Group and global enables, then a request held through a mask
	task automatic group_global;
		wr(PIEB_ADDR_EN_ONE, 8'h01);
		irq(32'h1, 1'b1);
		wr(PIEB_ADDR_CTRL, 8'h02);
		irq(32'h1, 1'b0);
		wr(PIEB_ADDR_CTRL, 8'h01);
		irq(32'h1, 1'b0);
		rd(PIEB_ADDR_STATUS, 8'h01);
		wr(PIEB_ADDR_CTRL, 8'h03);
		irq(32'h1, 1'b1);
		rd(PIEB_ADDR_STATUS, 8'h03);
		wr(PIEB_ADDR_EN_ONE, 8'h00);
		irq(32'h1, 1'b0);
		irq(32'h0, 1'b0);
	endtask
	// A strobe while the clock enable is low must leave state alone
	task automatic freeze_write;
		@(posedge ref_clk);
		clk_en <= 1'b0;
		wr(PIEB_ADDR_EN_ONE, 8'hff);
		clk_en <= 1'b1;
		rd(PIEB_ADDR_EN_ONE, 8'h00);
	endtask
	// Reset in mid-run clears what software had set
	task automatic mid_reset;
		wr(PIEB_ADDR_EN_TWO, 8'hff);
		wr(PIEB_ADDR_CTRL, 8'h03);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(PIEB_ADDR_EN_TWO, 8'h00);
		rd(PIEB_ADDR_CTRL, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		reset_values;
		reserved_bits;
		per_bit_gating;
		group_global;
		freeze_write;
		mid_reset;
		tally_and_finish;
	end
endmodule
